/* rtl/pcs_defs.svh */
// constants of the 100 Mbps coding sublayer
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_NIB_W 4
`define PCS_SYM_W 5
`define PCS_SYM_IDLE 5'h1f
`define PCS_SYM_J 5'h18
`define PCS_SYM_K 5'h11
`define PCS_SYM_T 5'h0d
`define PCS_SYM_R 5'h07
`define PCS_SYM_FC 5'h10
`define PCS_JK_PAIR 10'h311
`define PCS_WIN_W 10
`define PCS_LFSR_W 11
`define PCS_LFSR_SEED 11'h7ff
`define PCS_TAP_OLD 10
`define PCS_TAP_MID 8
`define PCS_LOCK_BITS 7'h3c
`define PCS_JK_WAIT 4'ha
`define PCS_LAST_BIT 3'h4
`define PCS_MLT_NEG 2'h0
`define PCS_MLT_ZERO 2'h1
`define PCS_MLT_POS 2'h2
`define PCS_BIT_RATE_MBPS 125
`define PCS_MII_CLK_MHZ 25
`define PCS_RXW_W 7
`define PCS_RXW_CRS 6
`define PCS_RXW_ER 5
`define PCS_RXW_DV 4

`endif

/* rtl/pcs_pkg.sv */
// types of the 100 Mbps coding sublayer
package pcs_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_t;
	typedef enum logic [1:0] {RX_HUNT, RX_IDLE, RX_CARRIER, RX_FRAME}
		rx_state_t;
	typedef enum logic [2:0] {SK_DATA, SK_IDLE, SK_J, SK_K, SK_T, SK_R,
		SK_FC, SK_BAD} sym_kind_t;
endpackage : pcs_pkg

/* rtl/pcs_cdc_fifo.sv */
// small gray-pointer fifo carrying code words between two clocks
`timescale 1ns/100ps
`default_nettype none
module pcs_cdc_fifo #(
	parameter int W = 7,
	parameter int AW = 2
) (
	input wire logic wclk,
	input wire logic wrst_b,
	input wire logic w_valid,
	input wire logic [W-1:0] w_data,
	output logic w_ready,
	input wire logic rclk,
	input wire logic rrst_b,
	output logic r_valid,
	output logic [W-1:0] r_data,
	input wire logic r_ready
);
	localparam int D = 1 << AW;

	initial begin
		if (AW < 1 || W < 1) $error("fifo shape not supported");
	end

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction : to_gray

	function automatic logic [AW:0] to_bin(input logic [AW:0] g);
		logic [AW:0] b;
		b = g;
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : to_bin

	logic [W-1:0] mem_r [D];
	logic [AW:0] wbin_r, wgray_r, rbin_r, rgray_r;
	logic [AW:0] rg1_r, rg2_r, rg3_r, rg_ok_r;
	logic [AW:0] wg1_r, wg2_r, wg3_r, wg_ok_r;

	wire [AW:0] wbin_nxt = wbin_r + (AW+1)'(1);
	wire [AW:0] rbin_nxt = rbin_r + (AW+1)'(1);
	wire [AW:0] fill = wbin_r - to_bin(rg_ok_r);
	wire do_wr = w_valid && w_ready;
	wire do_rd = r_valid && r_ready;

	assign w_ready = fill != (AW+1)'(D);
	assign r_valid = rbin_r != to_bin(wg_ok_r);
	assign r_data = mem_r[rbin_r[AW-1:0]];

	always_ff @(posedge wclk) begin
		if (do_wr) mem_r[wbin_r[AW-1:0]] <= w_data;
	end

	// pointer agreed only once the last two stages match
	always_ff @(posedge wclk or negedge wrst_b) begin
		if (!wrst_b) begin
			wbin_r <= '0;
			wgray_r <= '0;
			{rg1_r, rg2_r, rg3_r, rg_ok_r} <= '0;
		end else begin
			if (do_wr) begin
				wbin_r <= wbin_nxt;
				wgray_r <= to_gray(wbin_nxt);
			end
			rg1_r <= rgray_r;
			rg2_r <= rg1_r;
			rg3_r <= rg2_r;
			if (rg2_r == rg3_r) rg_ok_r <= rg3_r;
		end
	end

	always_ff @(posedge rclk or negedge rrst_b) begin
		if (!rrst_b) begin
			rbin_r <= '0;
			rgray_r <= '0;
			{wg1_r, wg2_r, wg3_r, wg_ok_r} <= '0;
		end else begin
			if (do_rd) begin
				rbin_r <= rbin_nxt;
				rgray_r <= to_gray(rbin_nxt);
			end
			wg1_r <= wgray_r;
			wg2_r <= wg1_r;
			wg3_r <= wg2_r;
			if (wg2_r == wg3_r) wg_ok_r <= wg3_r;
		end
	end
endmodule : pcs_cdc_fifo
`default_nettype wire

/* rtl/fast_ethernet_pcs_codec.sv */
// 100 Mbps coding sublayer: 4b/5b, scrambler, mlt-3, framing, errors
//
// Behaviour
// [R1] every tx nibble goes to the encoder; here a full crossing stalls the framer and the mac must hold its nibble
// [R2] nibbles 0 to 7 map to table codes
// [R3] nibbles 8 to f map; decoder inverts
// [R4] idle code 11111 between packets
// [R5] first preamble byte becomes j then k
// [R6] t then r after last nibble
// [R7] 10000 and 00111 are control, not data
// [R8] 11-bit lfsr, x[n] = x[n-11] ^ x[n-9]
// [R9] scrambled five-bit groups feed mlt-3
// [R10] groups serialised at 125 mbps
// [R11] mlt-3 holds level on zero bit
// [R12] levels cycle negative, zero, positive, zero
// [R13] rx order: mlt-3, descramble on idle, decode
// [R14] decoded nibbles go to the mac
// [R15] frame fields never interpreted
// [R16] carrier on two non-adjacent zeros in ten
// [R17] data passed only after full j k
// [R18] missing j k: drop carrier, flag error
// [R19] invalid code groups flag error
// [R20] idle mid-frame or link loss flags error
// [R21] error follows its condition at once
// [R22] collision only in half duplex, tx and rx
// [R23] nibble side clocked at 25 mhz
// [R24] group boundary set by j k position
// [R25] decode waits for lock; relock after frame
`include "pcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module fast_ethernet_pcs_codec #(
	parameter int FIFO_AW = 2
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_line,
	input wire logic tx_en,
	input wire logic [3:0] tx_d,
	input wire logic duplex_full,
	input wire logic link_ok,
	input wire logic rx_pos,
	input wire logic rx_neg,
	output logic tx_pos,
	output logic tx_neg,
	output logic rx_dv,
	output logic [3:0] rx_d,
	output logic rx_er,
	output logic crs,
	output logic col
);
	initial begin
		if (`PCS_BIT_RATE_MBPS / `PCS_MII_CLK_MHZ != `PCS_SYM_W) begin
			$error("bit rate and nibble clock disagree"); // see [R23]
		end
		if (FIFO_AW < 1) $error("fifo depth too small");
	end

	////////////////////////////////////////////////////////////////////
	// code tables

	function automatic logic [4:0] enc_nib(input logic [3:0] n);
		unique case (n) // see [R2]
			4'h0: enc_nib = 5'h1e;
			4'h1: enc_nib = 5'h09;
			4'h2: enc_nib = 5'h14;
			4'h3: enc_nib = 5'h15;
			4'h4: enc_nib = 5'h0a;
			4'h5: enc_nib = 5'h0b;
			4'h6: enc_nib = 5'h0e;
			4'h7: enc_nib = 5'h0f;
			4'h8: enc_nib = 5'h12; // see [R3]
			4'h9: enc_nib = 5'h13;
			4'ha: enc_nib = 5'h16;
			4'hb: enc_nib = 5'h17;
			4'hc: enc_nib = 5'h1a;
			4'hd: enc_nib = 5'h1b;
			4'he: enc_nib = 5'h1c;
			4'hf: enc_nib = 5'h1d;
		endcase
	endfunction : enc_nib

	// inverse table by search: {hit, nibble}
	function automatic logic [4:0] dec_sym(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < (1 << `PCS_NIB_W); i++) begin
			if (enc_nib(4'(i)) == c) r = {1'b1, 4'(i)}; // see [R3]
		end
		return r;
	endfunction : dec_sym

	function automatic pcs_pkg::sym_kind_t kind_of(input logic [4:0] c);
		logic [4:0] d;
		d = dec_sym(c);
		if (d[`PCS_NIB_W]) return pcs_pkg::SK_DATA;
		case (c)
			`PCS_SYM_IDLE: return pcs_pkg::SK_IDLE;
			`PCS_SYM_J: return pcs_pkg::SK_J;
			`PCS_SYM_K: return pcs_pkg::SK_K;
			`PCS_SYM_T: return pcs_pkg::SK_T;
			`PCS_SYM_R: return pcs_pkg::SK_R; // see [R7]
			`PCS_SYM_FC: return pcs_pkg::SK_FC; // see [R7]
			default: return pcs_pkg::SK_BAD; // see [R19]
		endcase
	endfunction : kind_of

	// two zeros with at least one bit between them
	function automatic logic gap_zeros(input logic [9:0] w);
		logic [9:0] z;
		logic r;
		z = ~w;
		r = 1'b0;
		for (int k = 2; k < `PCS_WIN_W; k++) begin
			r = r | (|(z & (z >> k)));
		end
		return r;
	endfunction : gap_zeros

	////////////////////////////////////////////////////////////////////
	// line reset release and pin synchronisers

	logic lrst1_r, rst_line_b;
	always_ff @(posedge clk_line or negedge rst_b) begin
		if (!rst_b) begin
			lrst1_r <= 1'b0;
			rst_line_b <= 1'b0;
		end else begin
			lrst1_r <= 1'b1;
			rst_line_b <= lrst1_r;
		end
	end

	logic [2:0] dup_s_r, link_s_r;
	logic dup_ok_r, link_ok_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dup_s_r <= 3'h0;
			dup_ok_r <= 1'b0;
		end else begin
			dup_s_r <= {dup_s_r[1:0], duplex_full};
			if (dup_s_r[1] == dup_s_r[2]) dup_ok_r <= dup_s_r[2];
		end
	end
	always_ff @(posedge clk_line or negedge rst_line_b) begin
		if (!rst_line_b) begin
			link_s_r <= 3'h0;
			link_ok_r <= 1'b0;
		end else begin
			link_s_r <= {link_s_r[1:0], link_ok};
			if (link_s_r[1] == link_s_r[2]) link_ok_r <= link_s_r[2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmit framing on the nibble clock

	pcs_pkg::tx_state_t tx_state_r, tx_state_nxt;
	logic [4:0] tx_sym;
	logic tx_step;

	// nibbles are coded blindly: preamble, sfd, payload and crc alike
	always_comb begin
		tx_state_nxt = tx_state_r;
		tx_sym = `PCS_SYM_IDLE; // see [R4]
		unique case (tx_state_r)
			pcs_pkg::TX_IDLE: if (tx_en) begin
				tx_sym = `PCS_SYM_J; // see [R5]
				tx_state_nxt = pcs_pkg::TX_K;
			end
			pcs_pkg::TX_K: begin
				tx_sym = `PCS_SYM_K; // see [R5]
				tx_state_nxt = pcs_pkg::TX_DATA;
			end
			pcs_pkg::TX_DATA: if (tx_en) begin
				tx_sym = enc_nib(tx_d); // see [R1] see [R15]
			end else begin
				tx_sym = `PCS_SYM_T; // see [R6]
				tx_state_nxt = pcs_pkg::TX_R;
			end
			pcs_pkg::TX_R: begin
				tx_sym = `PCS_SYM_R; // see [R6]
				tx_state_nxt = pcs_pkg::TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) tx_state_r <= pcs_pkg::TX_IDLE;
		else if (tx_step) tx_state_r <= tx_state_nxt; // see [R1]
	end

	tx_j_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // see [R5]
		tx_step && tx_state_r == pcs_pkg::TX_IDLE && tx_en |->
		tx_sym == `PCS_SYM_J ##1 tx_sym == `PCS_SYM_K)
		else $error("start delimiter not sent");
	tx_end_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // see [R6]
		tx_step && tx_state_r == pcs_pkg::TX_DATA && !tx_en |->
		tx_sym == `PCS_SYM_T ##1 tx_sym == `PCS_SYM_R)
		else $error("end delimiter not sent");
	tx_back_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // see [R6]
		tx_step && tx_state_r == pcs_pkg::TX_R |=>
		tx_state_r == pcs_pkg::TX_IDLE)
		else $error("framer did not return to idle");
	tx_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // see [R1]
		!tx_step |=> $stable(tx_state_r))
		else $error("framer moved while the crossing was full");
	tx_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // see [R4]
		tx_state_r == pcs_pkg::TX_IDLE && !tx_en |->
		tx_sym == `PCS_SYM_IDLE)
		else $error("idle not sent between frames");
	tx_data_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // see [R2]
		tx_state_r == pcs_pkg::TX_DATA && tx_en |->
		dec_sym(tx_sym) == {1'b1, tx_d})
		else $error("data code does not decode back");

	////////////////////////////////////////////////////////////////////
	// crossings; a symbol is offered every nibble clock, idle included

	logic [4:0] tx_fifo_sym;
	logic tx_fifo_vld, tx_load;
	logic [`PCS_RXW_W-1:0] rx_word, rx_fifo_word;
	logic rx_tick, rx_fifo_vld;

	// a full crossing stalls framing rather than dropping groups;
	// limitation: the mac must hold its nibble until the framer steps
	pcs_cdc_fifo #(.W(`PCS_SYM_W), .AW(FIFO_AW)) u_tx_cdc (
		.wclk(clk_sys),
		.wrst_b(rst_b),
		.w_valid(1'b1),
		.w_data(tx_sym),
		.w_ready(tx_step),
		.rclk(clk_line),
		.rrst_b(rst_line_b),
		.r_valid(tx_fifo_vld),
		.r_data(tx_fifo_sym),
		.r_ready(tx_load)
	);

	pcs_cdc_fifo #(.W(`PCS_RXW_W), .AW(FIFO_AW)) u_rx_cdc (
		.wclk(clk_line),
		.wrst_b(rst_line_b),
		.w_valid(rx_tick),
		.w_data(rx_word),
		.w_ready(),
		.rclk(clk_sys),
		.rrst_b(rst_b),
		.r_valid(rx_fifo_vld),
		.r_data(rx_fifo_word),
		.r_ready(1'b1)
	);

	////////////////////////////////////////////////////////////////////
	// line transmit: serialise, scramble, mlt-3

	logic [2:0] tx_ph_r;
	logic [4:0] tx_sh_r;
	logic [10:0] tx_key_r;
	logic [1:0] mlt_step_r;
	logic tx_pos_r, tx_neg_r;

	assign tx_load = tx_ph_r == `PCS_LAST_BIT;
	wire tx_key = tx_key_r[`PCS_TAP_OLD] ^ tx_key_r[`PCS_TAP_MID];
	wire tx_scr = tx_sh_r[`PCS_SYM_W-1] ^ tx_key; // see [R8] see [R9]
	wire [1:0] mlt_step_nxt = mlt_step_r + {1'b0, tx_scr}; // see [R11]
	wire [4:0] tx_next_sym = tx_fifo_vld ? tx_fifo_sym : `PCS_SYM_IDLE;

	always_ff @(posedge clk_line or negedge rst_line_b) begin
		if (!rst_line_b) begin
			tx_ph_r <= 3'h0;
			tx_sh_r <= `PCS_SYM_IDLE;
			tx_key_r <= `PCS_LFSR_SEED;
			mlt_step_r <= `PCS_MLT_ZERO;
			tx_pos_r <= 1'b0;
			tx_neg_r <= 1'b0;
		end else begin
			tx_ph_r <= tx_load ? 3'h0 : tx_ph_r + 3'h1; // see [R10]
			tx_sh_r <= tx_load ? tx_next_sym : {tx_sh_r[3:0], 1'b0};
			tx_key_r <= {tx_key_r[9:0], tx_key}; // see [R8]
			mlt_step_r <= mlt_step_nxt; // see [R12]
			tx_pos_r <= mlt_step_nxt == `PCS_MLT_POS;
			tx_neg_r <= mlt_step_nxt == `PCS_MLT_NEG;
		end
	end
	assign tx_pos = tx_pos_r;
	assign tx_neg = tx_neg_r;

	mlt_hold_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
		!tx_scr |=> $stable(tx_pos_r) && $stable(tx_neg_r)) // see [R11]
		else $error("mlt-3 level moved on a zero bit");
	mlt_order_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
		tx_pos_r |=> !tx_neg_r) // see [R12]
		else $error("mlt-3 jumped from positive to negative");
	scram_seq_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
		$past(rst_line_b, 12) |-> tx_key_r[0] ==
		($past(tx_key_r[0], 11) ^ $past(tx_key_r[0], 9))) // see [R8]
		else $error("scrambler sequence broken");

	////////////////////////////////////////////////////////////////////
	// line receive: mlt-3 decode, descramble, align, decode

	pcs_pkg::rx_state_t rx_state_r, rx_state_nxt;
	pcs_pkg::sym_kind_t rx_kind;
	logic [1:0] rx_lvl_r;
	logic [10:0] rx_key_r;
	logic [6:0] lock_cnt_r;
	logic [9:0] win_r;
	logic [2:0] rx_ph_r, rx_ph_nxt;
	logic [3:0] wait_r, wait_nxt;
	logic ev_pend_r, rx_dv_l, rx_err_l, rx_ev;

	wire mlt_bit = {rx_pos, rx_neg} != rx_lvl_r; // see [R13]
	wire hunting = rx_state_r == pcs_pkg::RX_HUNT;
	wire rx_pred = rx_key_r[`PCS_TAP_OLD] ^ rx_key_r[`PCS_TAP_MID];
	// idle carries all ones, so the line bit inverted is the key bit
	wire rx_bit = hunting ? 1'b1 : mlt_bit ^ rx_pred; // see [R25]
	wire [10:0] rx_key_nxt = {rx_key_r[9:0], hunting ? ~mlt_bit : rx_pred};
	wire lock_hit = hunting && rx_pred == ~mlt_bit;
	wire locked_now = lock_hit && lock_cnt_r == `PCS_LOCK_BITS - 7'h1;
	wire [9:0] win_nxt = {win_r[8:0], rx_bit};
	wire cs_hit = gap_zeros(win_nxt); // see [R16]
	wire jk_hit = win_nxt == `PCS_JK_PAIR; // see [R17]
	wire [4:0] rx_sym = win_nxt[4:0];
	wire [4:0] rx_dec = dec_sym(rx_sym);
	assign rx_tick = rx_ph_r == `PCS_LAST_BIT;
	assign rx_kind = kind_of(rx_sym);
	wire crs_l = rx_state_nxt == pcs_pkg::RX_CARRIER ||
		rx_state_nxt == pcs_pkg::RX_FRAME;

	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_ph_nxt = rx_tick ? 3'h0 : rx_ph_r + 3'h1;
		wait_nxt = wait_r;
		rx_dv_l = 1'b0;
		rx_err_l = 1'b0;
		rx_ev = 1'b0;
		unique case (rx_state_r)
			pcs_pkg::RX_HUNT: if (locked_now) begin
				rx_state_nxt = pcs_pkg::RX_IDLE; // see [R25]
			end
			pcs_pkg::RX_IDLE: if (!link_ok_r) begin
				rx_state_nxt = pcs_pkg::RX_HUNT;
			end else if (cs_hit) begin
				rx_state_nxt = pcs_pkg::RX_CARRIER; // see [R16]
				wait_nxt = 4'h0;
			end
			pcs_pkg::RX_CARRIER: if (jk_hit) begin
				rx_state_nxt = pcs_pkg::RX_FRAME;
				rx_ph_nxt = 3'h0; // see [R24]
			end else if (wait_r == `PCS_JK_WAIT) begin
				rx_state_nxt = pcs_pkg::RX_HUNT; // see [R18]
				rx_ev = 1'b1;
			end else begin
				wait_nxt = wait_r + 4'h1;
			end
			pcs_pkg::RX_FRAME: if (!link_ok_r) begin
				rx_state_nxt = pcs_pkg::RX_HUNT; // see [R20]
				rx_ev = 1'b1;
			end else if (rx_tick) begin
				unique case (rx_kind)
					pcs_pkg::SK_DATA: rx_dv_l = 1'b1; // see [R14]
					pcs_pkg::SK_T: rx_state_nxt = pcs_pkg::RX_HUNT; // see [R25]
					pcs_pkg::SK_IDLE: begin
						rx_err_l = 1'b1; // see [R20]
						rx_state_nxt = pcs_pkg::RX_HUNT;
					end
					pcs_pkg::SK_BAD: rx_err_l = 1'b1; // see [R19]
					pcs_pkg::SK_J, pcs_pkg::SK_K, pcs_pkg::SK_R,
						pcs_pkg::SK_FC: rx_err_l = 1'b0; // see [R7]
				endcase
			end
		endcase
	end

	// a word per group; er carries events seen since the last word
	assign rx_word = {crs_l, rx_err_l | rx_ev | ev_pend_r, rx_dv_l,
		rx_dec[3:0]}; // see [R21]

	always_ff @(posedge clk_line or negedge rst_line_b) begin
		if (!rst_line_b) begin
			rx_state_r <= pcs_pkg::RX_HUNT;
			rx_lvl_r <= 2'h0;
			rx_key_r <= `PCS_LFSR_SEED;
			lock_cnt_r <= 7'h00;
			win_r <= 10'h3ff;
			rx_ph_r <= 3'h0;
			wait_r <= 4'h0;
			ev_pend_r <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_lvl_r <= {rx_pos, rx_neg};
			rx_key_r <= rx_key_nxt; // see [R13]
			lock_cnt_r <= lock_hit ? lock_cnt_r + 7'h1 : 7'h00;
			win_r <= win_nxt;
			rx_ph_r <= rx_ph_nxt;
			wait_r <= wait_nxt;
			ev_pend_r <= rx_ev | (ev_pend_r & !rx_tick);
		end
	end

	frame_jk_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
		rx_state_r != pcs_pkg::RX_FRAME ##1 rx_state_r == pcs_pkg::RX_FRAME
		|-> $past(jk_hit) && rx_ph_r == 3'h0) // see [R17]
		else $error("frame entered without start delimiter");
	false_crs_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
		rx_state_r == pcs_pkg::RX_CARRIER && !jk_hit &&
		wait_r == `PCS_JK_WAIT |-> !crs_l ##1 ev_pend_r || rx_tick) // see [R18]
		else $error("false carrier not dropped and flagged");
	bad_err_a: assert property (@(posedge clk_line) disable iff (!rst_line_b)
		rx_state_r == pcs_pkg::RX_FRAME && link_ok_r && rx_tick &&
		rx_kind == pcs_pkg::SK_BAD |-> rx_word[`PCS_RXW_ER]) // see [R19]
		else $error("invalid group not flagged");

	////////////////////////////////////////////////////////////////////
	// nibble side receive outputs and collision

	logic rx_dv_r, rx_er_r, crs_r, col_r;
	logic [3:0] rx_d_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rx_dv_r <= 1'b0;
			rx_er_r <= 1'b0;
			crs_r <= 1'b0;
			rx_d_r <= 4'h0;
			col_r <= 1'b0;
		end else begin
			if (rx_fifo_vld) begin
				rx_dv_r <= rx_fifo_word[`PCS_RXW_DV]; // see [R14]
				rx_er_r <= rx_fifo_word[`PCS_RXW_ER]; // see [R21]
				crs_r <= rx_fifo_word[`PCS_RXW_CRS];
				rx_d_r <= rx_fifo_word[3:0];
			end
			col_r <= !dup_ok_r && crs_r &&
				(tx_en || tx_state_r != pcs_pkg::TX_IDLE); // see [R22]
		end
	end
	assign rx_dv = rx_dv_r;
	assign rx_er = rx_er_r;
	assign crs = crs_r;
	assign rx_d = rx_d_r;
	assign col = col_r;

	col_half_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		col_r |-> !$past(dup_ok_r) && $past(crs_r)) // see [R22]
		else $error("collision outside half duplex reception");
endmodule : fast_ethernet_pcs_codec
`default_nettype wire

/* test/line_far_end.sv */
// far end of the twisted pair: scrambled mlt-3 in both directions
`timescale 1ns/100ps
`default_nettype none
module line_far_end (
	input wire logic clk_line,
	input wire logic rst_b,
	input wire logic tx_pos,
	input wire logic tx_neg,
	output logic rx_pos,
	output logic rx_neg
);
	logic [4:0] out_q[$];
	logic [4:0] got_q[$];
	int mlt_bad;
	logic [10:0] ks;
	logic [10:0] kr;
	logic [9:0] sh;
	logic [4:0] cur;
	logic [1:0] idx;
	logic [1:0] plvl;
	logic [1:0] lastnz;
	int bc;
	int cnt;
	int pos;
	logic al;
	logic tl;
	////////////////////////////////////////////////////////////////////////
	// send side: idle fills every gap, the line never goes quiet
	always @(posedge clk_line or negedge rst_b) begin : send_p
		logic b;
		if (!rst_b) begin
			ks = 11'h7ff;
			idx = 2'h1;
			bc = 0;
			rx_pos <= 1'b0;
			rx_neg <= 1'b0;
		end else begin
			if (bc == 0) begin
				cur = 5'h1f;
				if (out_q.size() > 0)
					cur = out_q.pop_front();
			end
			b = cur[4 - bc] ^ ks[10] ^ ks[8];
			ks = {ks[9:0], ks[10] ^ ks[8]};
			bc = (bc == 4) ? 0 : bc + 1;
			if (b)
				idx = idx + 2'h1;
			rx_pos <= (idx == 2'h2);
			rx_neg <= (idx == 2'h0);
		end
	end
	////////////////////////////////////////////////////////////////////////
	// receive side: key learnt from idle, groups aligned on j k
	always @(posedge clk_line or negedge rst_b) begin : recv_p
		logic b;
		logic p;
		logic kn;
		logic [1:0] lvl;
		if (!rst_b) begin
			kr = 11'h0;
			plvl = 2'h0;
			lastnz = 2'h0;
			cnt = 0;
			al = 1'b0;
			tl = 1'b0;
			sh = 10'h0;
			pos = 0;
			mlt_bad = 0;
		end else begin
			lvl = {tx_pos, tx_neg};
			b = (lvl != plvl);
			if (b && (lvl == 2'h3 || (plvl != 2'h0 && lvl != 2'h0)
				|| (plvl == 2'h0 && lvl == lastnz)))
				mlt_bad++;
			if (lvl != 2'h0)
				lastnz = lvl;
			plvl = lvl;
			kn = kr[10] ^ kr[8];
			p = (cnt < 60) ? 1'b1 : b ^ kn;
			kr = {kr[9:0], (cnt < 60) ? ~b : kn};
			if (cnt < 60)
				cnt++;
			sh = {sh[8:0], p};
			if (!al && sh == 10'h311) begin
				al = 1'b1;
				pos = 0;
				got_q.push_back(5'h18);
				got_q.push_back(5'h11);
			end else if (al) begin
				pos = pos + 1;
				if (pos == 5) begin
					pos = 0;
					got_q.push_back(sh[4:0]);
					al = !(tl || sh[4:0] == 5'h1f);
					tl = (sh[4:0] == 5'h0d);
				end
			end
		end
	end
endmodule : line_far_end
`default_nettype wire

/* test/fast_ethernet_pcs_codec_bench.sv */
// self-checking bench of the 100 mbps coding sublayer
`timescale 1ns/100ps
`default_nettype none
module fast_ethernet_pcs_codec_bench;
	localparam logic [4:0] enc_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
		5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a,
		5'h1b, 5'h1c, 5'h1d};
	localparam logic [4:0] bad_tab [6] = '{5'h00, 5'h04, 5'h08, 5'h0c,
		5'h19, 5'h1f};
	logic clk_sys, clk_line, rst_b, tx_en, duplex_full, link_ok;
	logic [3:0] tx_d;
	logic tx_pos, tx_neg, rx_pos, rx_neg, rx_dv, rx_er, crs, col;
	logic [3:0] rx_d;
	logic [4:0] exp_sym[$];
	logic [3:0] exp_nib[$];
	logic chk_rx, er_seen, col_seen, crs_seen, pdv;
	logic [3:0] pd;
	int fail_count = 0;
	int n_compared = 0;
	fast_ethernet_pcs_codec #(.FIFO_AW(2)) DUT (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_line(clk_line),
		.tx_en(tx_en),
		.tx_d(tx_d),
		.duplex_full(duplex_full),
		.link_ok(link_ok),
		.rx_pos(rx_pos),
		.rx_neg(rx_neg),
		.tx_pos(tx_pos),
		.tx_neg(tx_neg),
		.rx_dv(rx_dv),
		.rx_d(rx_d),
		.rx_er(rx_er),
		.crs(crs),
		.col(col)
	);
	line_far_end far (
		.clk_line(clk_line),
		.rst_b(rst_b),
		.tx_pos(tx_pos),
		.tx_neg(tx_neg),
		.rx_pos(rx_pos),
		.rx_neg(rx_neg)
	);
	////////////////////////////////////////////////////////////////////////
	// 25 mhz nibble clock; line clock 80 ns, phase unrelated
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		clk_line = 1'b0;
		#13;
		forever #40 clk_line = ~clk_line;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic cmp_sym(input logic [4:0] got, input logic [4:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t line group %h not %h", $time, got, exp);
		end
	endtask : cmp_sym
	task automatic cmp_nib(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t rx nibble %h not %h", $time, got, exp);
		end
	endtask : cmp_nib
	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t flag %b not %b", $time, got, exp);
		end
	endtask : cmp_bit
	// inputs always move 2 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick
	task automatic wait_line;
		for (int i = 0; i < 5000 && far.out_q.size() > 0; i++)
			tick(1);
		if (far.out_q.size() > 0) begin
			fail_count++;
			$display("[ERR] %0t line model never drained", $time);
			give_verdict();
		end
		tick(200); // long enough for the receiver to relock on idle
	endtask : wait_line
	// the framer steps only when the crossing has room; hold until then
	task automatic tx_take;
		while (DUT.tx_step !== 1'b1)
			tick(1);
		tick(1);
	endtask : tx_take
	task automatic tx_frame(input int n);
		logic [3:0] d;
		for (int i = 0; i < n; i++) begin
			d = 4'($urandom);
			tx_en = 1'b1;
			tx_d = d;
			if (i == 0)
				exp_sym.push_back(5'h18);
			else if (i == 1)
				exp_sym.push_back(5'h11);
			else
				exp_sym.push_back(enc_tab[d]);
			tx_take;
		end
		tx_en = 1'b0;
		exp_sym.push_back(5'h0d);
		exp_sym.push_back(5'h07);
		tx_take;
		tx_take;
	endtask : tx_frame
	// neighbours differ so each new word shows as a change of rx_d
	task automatic rx_frame(input int n);
		logic [3:0] d;
		logic [3:0] q;
		q = 4'h0;
		far.out_q.push_back(5'h18);
		far.out_q.push_back(5'h11);
		for (int i = 0; i < n; i++) begin
			d = (n == 16) ? 4'(i) : 4'($urandom);
			if (i > 0 && d == q)
				d = d + 4'h1;
			q = d;
			far.out_q.push_back(enc_tab[d]);
			exp_nib.push_back(d);
		end
		far.out_q.push_back(5'h0d);
		far.out_q.push_back(5'h07);
	endtask : rx_frame
	// m 0: bad group in frame, 1: false carrier, 2: link lost in frame
	task automatic rx_bad(input logic [4:0] g, input int m);
		chk_rx = 1'b0;
		er_seen = 1'b0;
		far.out_q.push_back(5'h18);
		if (m != 1) begin
			far.out_q.push_back(5'h11);
			repeat ((m == 2) ? 12 : 1) far.out_q.push_back(5'h1e);
			far.out_q.push_back(g);
			if (g != 5'h1f) begin
				far.out_q.push_back(5'h0d);
				far.out_q.push_back(5'h07);
			end
		end
		if (m == 2) begin
			tick(40);
			link_ok = 1'b0;
			tick(20);
			link_ok = 1'b1;
		end
		wait_line;
		cmp_bit(er_seen, 1'b1);
		cmp_bit(crs, 1'b0);
		chk_rx = 1'b1;
	endtask : rx_bad
	////////////////////////////////////////////////////////////////////////
	initial begin : sym_watch
		logic [4:0] g;
		forever begin
			wait (far.got_q.size() > 0);
			g = far.got_q.pop_front();
			if (exp_sym.size() > 0)
				cmp_sym(g, exp_sym.pop_front());
			else
				cmp_sym(g, 5'h1f);
		end
	end
	// outputs settle after the rising edge; look at them mid-cycle
	always @(negedge clk_sys) begin
		if (rx_dv === 1'b1 && chk_rx && (pdv !== 1'b1 || rx_d !== pd)) begin
			if (exp_nib.size() > 0)
				cmp_nib(rx_d, exp_nib.pop_front());
			else
				cmp_bit(rx_dv, 1'b0);
		end
		pdv = rx_dv;
		pd = rx_d;
		if (rx_er === 1'b1)
			er_seen = 1'b1;
		if (col === 1'b1)
			col_seen = 1'b1;
		if (crs === 1'b1)
			crs_seen = 1'b1;
	end
	initial begin
		#1000000;
		fail_count++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		tx_en = 1'b0;
		tx_d = 4'h0;
		duplex_full = 1'b1;
		link_ok = 1'b1;
		chk_rx = 1'b1;
		er_seen = 1'b0;
		col_seen = 1'b0;
		crs_seen = 1'b0;
		void'($urandom(89));
		tick(6);
		rst_b = 1'b1;
		tick(200);
		tx_frame(8 + $urandom_range(0, 8));
		tx_frame(2);
		rx_frame(16);
		wait_line;
		cmp_bit(crs_seen, 1'b1);
		cmp_bit(er_seen, 1'b0);
		rx_frame(9);
		wait_line;
		foreach (bad_tab[i])
			rx_bad(bad_tab[i], 0);
		rx_bad(5'h1f, 1);
		rx_bad(5'h1e, 2);
		for (int d = 0; d < 2; d++) begin
			duplex_full = 1'(d);
			tick(5);
			col_seen = 1'b0;
			rx_frame(10);
			tick(30);
			tx_frame(40);
			wait_line;
			cmp_bit(col_seen, ~1'(d));
		end
		tick(100);
		cmp_bit(exp_sym.size() == 0, 1'b1);
		cmp_bit(exp_nib.size() == 0, 1'b1);
		cmp_bit(far.mlt_bad == 0, 1'b1);
		give_verdict();
	end
endmodule : fast_ethernet_pcs_codec_bench
`default_nettype wire
